// File: common/lim_pkg.sv
package lim_pkg;

  typedef logic [15:0] lim_reg_t;
  typedef logic [3:0] lim_evt_t;

  localparam int unsigned LIM_REG_W = 16;
  localparam int unsigned LIM_IDX_W = 30;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_G1_STATUS = 30'h0A00_0080;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_G1_ENABLE = 30'h0A00_008C;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_ROUTE = 30'h0A00_0098;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_SW_TRIGGER = 30'h0A00_009A;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_G2_STATUS = 30'h0A00_0200;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_EVT_STATUS = 30'h0A00_00A0;
  localparam logic [LIM_IDX_W-1:0] LIM_IDX_EVT_MASK = 30'h0A00_00A2;

  // First level-1 group bit positions
  localparam int unsigned LIM_B1_TOUCH_SUSPEND = 13;
  localparam int unsigned LIM_B1_SOFTWARE = 11;
  localparam int unsigned LIM_B1_SERIAL = 9;
  localparam int unsigned LIM_B1_GPIO = 8;
  localparam int unsigned LIM_B1_KEYBOARD = 7;
  localparam int unsigned LIM_B1_AUDIO = 6;
  localparam int unsigned LIM_B1_TOUCH = 5;
  localparam int unsigned LIM_B1_ELAPSED = 3;
  localparam int unsigned LIM_B1_LONG_TIMER1 = 2;
  localparam int unsigned LIM_B1_POWER = 1;
  localparam int unsigned LIM_B1_BATTERY = 0;

  // Second level-1 group bit positions
  localparam int unsigned LIM_B2_DISPLAY = 6;
  localparam int unsigned LIM_B2_DMA = 5;
  localparam int unsigned LIM_B2_CLOCKED_SERIAL = 3;
  localparam int unsigned LIM_B2_MEMORY_CARD = 2;
  localparam int unsigned LIM_B2_LED = 1;
  localparam int unsigned LIM_B2_LONG_TIMER2 = 0;

  localparam int unsigned LIM_ROUTE_SELECT_BIT = 0;
  localparam int unsigned LIM_SW_REQUEST_BIT = 0;

  // Implemented bits of each register; all others read zero
  localparam lim_reg_t LIM_G1_IMPL = 16'h2BEF;
  localparam lim_reg_t LIM_G2_IMPL = 16'h006F;
  localparam lim_reg_t LIM_ROUTE_IMPL = 16'h0001;

  // Event bits of the own status and mask registers
  localparam int unsigned LIM_EV_NMI = 0;
  localparam int unsigned LIM_EV_LINE0 = 1;
  localparam int unsigned LIM_EV_LINE1 = 2;
  localparam int unsigned LIM_EV_LINE2 = 3;
  localparam int unsigned LIM_EV_W = 4;

  // Reset values
  localparam lim_reg_t LIM_RST_G1_ENABLE = 16'h0000;
  localparam lim_reg_t LIM_RST_ROUTE = 16'h0000;
  localparam logic LIM_RST_SW_PENDING = 1'h0;
  localparam lim_evt_t LIM_RST_EVT = 4'h0;

endpackage : lim_pkg

// File: common/lim_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

interface lim_bus_if;
  import lim_pkg::*;
  logic wr_stb;
  logic [LIM_IDX_W-1:0] idx;
  logic [LIM_REG_W-1:0] wdata;
  logic [1:0] be;
  logic [LIM_REG_W-1:0] rdata;

  modport slave (output wr_stb, output idx, output wdata, output be, input rdata);
  modport regs (input wr_stb, input idx, input wdata, input be, output rdata);
endinterface : lim_bus_if

`default_nettype wire

// File: rtl/lim_wb_slave.sv
`timescale 1ns/100ps
`default_nettype none

module lim_wb_slave
  import lim_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register side
  lim_bus_if.slave bus
);

  logic ack_q;
  logic [31:0] dat_q;
  wire req = wb_cyc_i & wb_stb_i;

  // Write lands on the edge where the master sees ack
  assign bus.wr_stb = req & wb_we_i & ack_q;
  assign bus.idx = wb_adr_i[31:2];
  assign bus.wdata = wb_dat_i[LIM_REG_W-1:0];
  assign bus.be = wb_sel_i[1:0];

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= {16'h0000, bus.rdata};
    end
  end

endmodule : lim_wb_slave

`default_nettype wire

// File: rtl/lim_irq_top.sv
// Notes on behaviour
// - Enable bits 13,11,9,8,7,6,5,3,2,1,0 are read/write; one forwards, zero blocks.
// - Bit 13 gates suspend-mode touch request; bit 5 gates the normal touch request.
// - Bit 1 gates power-switch request; bit 0 gates battery-low request.
// - Bit 3 gates elapsed-time timer; bit 2 gates first long-interval timer.
// - Reserved and unused upper bits always read back zero.
// - Route bit 0: zero sends battery-low to NMI, one to line zero.
// - Trigger write of one sets software pending; write of zero clears it.
// - Trigger is write-only; pending shows only in first group status bit 11.
// - Second group status is read-only: display, DMA, serial, card, LED, timer2.
// - Each status bit is ANDed with its enable before reaching the CPU.
// - First and second long-interval timers drive lines one and two; battery-low follows route bit 0; all other enabled requests OR onto line zero.
// - Group inputs arrive already merged per level-2 unit or set directly.
`timescale 1ns/100ps
`default_nettype none

module lim_irq_top
  import lim_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Level-1 request inputs from the peripheral units
  input wire logic [LIM_REG_W-1:0] group1_request,
  input wire logic [LIM_REG_W-1:0] group2_request,
  input wire logic [LIM_REG_W-1:0] group2_enable,
  // CPU core interrupt lines, active high
  output logic cpu_nmi,
  output logic cpu_general_line_zero,
  output logic cpu_line_one,
  output logic cpu_line_two,
  // Summary interrupt for software
  output logic irq
);

  lim_bus_if bus ();

  lim_wb_slave u_slave (
    .clk_sys (clk_sys),
    .srst (srst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .bus (bus)
  );

  // Register state
  wire lim_reg_t enable_q;
  lim_reg_t route_q;
  logic route_sel_q;
  logic sw_pending_q;
  logic sw_pending_d;
  lim_evt_t evt_status_q;
  lim_evt_t evt_status_d;
  lim_evt_t evt_mask_q;
  lim_evt_t evt_mask_d;
  lim_evt_t lines_q;
  lim_evt_t lines_d;
  logic irq_q;

  // Address decode
  wire hit_g1_status = (bus.idx == LIM_IDX_G1_STATUS);
  wire hit_g1_enable = (bus.idx == LIM_IDX_G1_ENABLE);
  wire hit_route = (bus.idx == LIM_IDX_ROUTE);
  wire hit_sw_trigger = (bus.idx == LIM_IDX_SW_TRIGGER);
  wire hit_g2_status = (bus.idx == LIM_IDX_G2_STATUS);
  wire hit_evt_status = (bus.idx == LIM_IDX_EVT_STATUS);
  wire hit_evt_mask = (bus.idx == LIM_IDX_EVT_MASK);

  wire wr_lo = bus.wr_stb & bus.be[0];
  wire wr_g1_enable = bus.wr_stb & hit_g1_enable;
  wire wr_route = wr_lo & hit_route;
  wire wr_sw_trigger = wr_lo & hit_sw_trigger;
  wire wr_evt_status = wr_lo & hit_evt_status;
  wire wr_evt_mask = wr_lo & hit_evt_mask;

  // Status views; software pending rides in bit 11 of the first group
  lim_reg_t g1_status;
  lim_reg_t g2_status;
  assign g1_status = ((group1_request & ~(16'h0001 << LIM_B1_SOFTWARE))
                      | ({15'h0000, sw_pending_q} << LIM_B1_SOFTWARE))
                     & LIM_G1_IMPL;
  assign g2_status = group2_request & LIM_G2_IMPL;

  // Read mux; unmapped and write-only indices read zero
  always_comb begin
    if (hit_g1_status) begin
      bus.rdata = g1_status;
    end else if (hit_g1_enable) begin
      bus.rdata = enable_q & LIM_G1_IMPL;
    end else if (hit_route) begin
      bus.rdata = route_q & LIM_ROUTE_IMPL;
    end else if (hit_g2_status) begin
      bus.rdata = g2_status;
    end else if (hit_evt_status) begin
      bus.rdata = {12'h000, evt_status_q};
    end else if (hit_evt_mask) begin
      bus.rdata = {12'h000, evt_mask_q};
    end else begin
      bus.rdata = 16'h0000;
    end
  end

  // Enable register, one flop per implemented bit, honouring byte lanes
  genvar gi;
  generate
    for (gi = 0; gi < LIM_REG_W; gi = gi + 1) begin : g_enable
      if (LIM_G1_IMPL[gi]) begin : g_impl
        wire wr_bit = wr_g1_enable & bus.be[gi / 8];
        logic bit_q;
        // Each bit owns its flop so the vector has one driver per bit
        always_ff @(posedge clk_sys) begin
          if (srst) begin
            bit_q <= LIM_RST_G1_ENABLE[gi];
          end else if (wr_bit) begin
            bit_q <= bus.wdata[gi];
          end
        end
        assign enable_q[gi] = bit_q;
      end else begin : g_resv
        assign enable_q[gi] = 1'b0;
      end
    end
  endgenerate

  // Route register: only bit 0 is storage
  assign route_q = {15'h0000, route_sel_q} << LIM_ROUTE_SELECT_BIT;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      route_sel_q <= LIM_RST_ROUTE[LIM_ROUTE_SELECT_BIT];
    end else if (wr_route) begin
      route_sel_q <= bus.wdata[LIM_ROUTE_SELECT_BIT];
    end
  end

  // Software request: a write of either value overwrites pending
  assign sw_pending_d = wr_sw_trigger ? bus.wdata[LIM_SW_REQUEST_BIT] : sw_pending_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw_pending_q <= LIM_RST_SW_PENDING;
    end else begin
      sw_pending_q <= sw_pending_d;
    end
  end

  // Gating and line steering
  lim_reg_t g1_active;
  lim_reg_t g2_active;
  lim_reg_t g1_to_line0;
  lim_reg_t g2_to_line0;
  wire battery_active;
  wire battery_on_line0;

  assign g1_active = g1_status & enable_q;
  assign g2_active = g2_status & group2_enable;
  assign battery_active = g1_active[LIM_B1_BATTERY];
  assign battery_on_line0 = route_q[LIM_ROUTE_SELECT_BIT];

  // Long-interval timer and battery bits are taken off the shared line
  assign g1_to_line0 = g1_active
                       & ~(16'h0001 << LIM_B1_LONG_TIMER1)
                       & ~(16'h0001 << LIM_B1_BATTERY);
  assign g2_to_line0 = g2_active & ~(16'h0001 << LIM_B2_LONG_TIMER2);

  always_comb begin
    lines_d = 4'h0;
    lines_d[LIM_EV_NMI] = battery_active & ~battery_on_line0;
    lines_d[LIM_EV_LINE0] = (|g1_to_line0) | (|g2_to_line0)
                            | (battery_active & battery_on_line0);
    lines_d[LIM_EV_LINE1] = g1_active[LIM_B1_LONG_TIMER1];
    lines_d[LIM_EV_LINE2] = g2_active[LIM_B2_LONG_TIMER2];
  end

  // Lines are registered so the core sees glitch-free levels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lines_q <= LIM_RST_EVT;
    end else begin
      lines_q <= lines_d;
    end
  end

  assign cpu_nmi = lines_q[LIM_EV_NMI];
  assign cpu_general_line_zero = lines_q[LIM_EV_LINE0];
  assign cpu_line_one = lines_q[LIM_EV_LINE1];
  assign cpu_line_two = lines_q[LIM_EV_LINE2];

  // Sticky events on each rising CPU line; set beats a same-cycle clear
  lim_evt_t line_rise;
  assign line_rise = lines_d & ~lines_q;

  always_comb begin
    evt_status_d = evt_status_q;
    if (wr_evt_status) begin
      evt_status_d = evt_status_q & ~bus.wdata[LIM_EV_W-1:0];
    end
    evt_status_d = evt_status_d | line_rise;
  end

  assign evt_mask_d = wr_evt_mask ? bus.wdata[LIM_EV_W-1:0] : evt_mask_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evt_status_q <= LIM_RST_EVT;
      evt_mask_q <= LIM_RST_EVT;
      irq_q <= 1'b0;
    end else begin
      evt_status_q <= evt_status_d;
      evt_mask_q <= evt_mask_d;
      irq_q <= |(evt_status_d & evt_mask_d);
    end
  end

  assign irq = irq_q;

endmodule : lim_irq_top

`default_nettype wire

// File: sim/lim_irq_checker.sv
`timescale 1ns/100ps
`default_nettype none

module lim_irq_checker
  import lim_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Requests
  input wire logic [LIM_REG_W-1:0] group1_request,
  input wire logic [LIM_REG_W-1:0] group2_request,
  input wire logic [LIM_REG_W-1:0] group2_enable,
  // Lines
  input wire logic cpu_nmi,
  input wire logic cpu_general_line_zero,
  input wire logic cpu_line_one,
  input wire logic cpu_line_two,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire logic req_w = wb_cyc_i && wb_stb_i;
  wire logic rd_w = wb_ack_o && !wb_we_i;

  a_ack_answers: assert property (req_w && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_trig_reads_zero: assert property (rd_w && wb_adr_i[31:2] == LIM_IDX_SW_TRIGGER
    |-> wb_dat_o == 32'h0000_0000) else $error("trigger read not zero");
  a_g2_reserved_zero: assert property (rd_w && wb_adr_i[31:2] == LIM_IDX_G2_STATUS
    |-> (wb_dat_o[15:0] & ~LIM_G2_IMPL) == 16'h0000) else $error("group2 reserved set");
  a_line_two_gate: assert property (1'b1 |=>
    cpu_line_two == $past(group2_request[0] & group2_enable[0])) else $error("line two wrong");
  a_nmi_cause: assert property (cpu_nmi |-> $past(group1_request[0]))
    else $error("nmi without battery request");
  a_line_one_cause: assert property (cpu_line_one |-> $past(group1_request[2]))
    else $error("line one without timer request");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=>
    {cpu_nmi, cpu_general_line_zero, cpu_line_one, cpu_line_two, irq} == 5'h00)
    else $error("outputs active after reset");

  cover property ($rose(cpu_nmi));
  cover property ($rose(cpu_general_line_zero));
  cover property ($rose(irq));
endmodule : lim_irq_checker

`default_nettype wire

// File: sim/lim_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module lim_cpu_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Lines nmi, zero, one, two
  input wire logic [3:0] line,
  output logic [3:0] seen
);
  // Sticky, so a line that drops between polls is not lost
  always_ff @(posedge clk_sys) begin
    seen <= srst ? 4'h0 : (seen | line);
  end
endmodule : lim_cpu_model

`default_nettype wire

// File: sim/lim_irq_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module lim_irq_tb_top;
  import lim_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, rdat;
  logic [3:0] sel = 4'h0, seen;
  logic [15:0] g1 = 16'h0, g2 = 16'h0, g2en = 16'h0;
  logic ack, nmi, l0, l1, l2, irq;
  int bad_count = 0, checked = 0;
  wire logic [3:0] lns = {nmi, l0, l1, l2};
  always #25 clk_sys = ~clk_sys;
  lim_irq_top dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .group1_request(g1), .group2_request(g2), .group2_enable(g2en),
    .cpu_nmi(nmi), .cpu_general_line_zero(l0), .cpu_line_one(l1), .cpu_line_two(l2),
    .irq(irq));
  lim_cpu_model cpu (.clk_sys(clk_sys), .srst(srst), .line(lns), .seen(seen));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [29:0] ix, input logic [15:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= s;
    dat <= {16'h0000, d};
    @(posedge clk_sys iff ack);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [29:0] ix, input logic [15:0] d);
    logic [31:0] r;
    wb(1'b1, ix, d, 4'h3, r);
  endtask : wr
  task automatic rd(input logic [29:0] ix, input logic [15:0] e);
    logic [31:0] r;
    wb(1'b0, ix, 16'h0000, 4'h3, r);
    chk("register", r, {16'h0000, e});
  endtask : rd
  task automatic t_reset;
    rd(LIM_IDX_G1_ENABLE, 16'h0000);
    rd(LIM_IDX_ROUTE, 16'h0000);
    rd(LIM_IDX_G1_STATUS, 16'h0000);
    rd(LIM_IDX_G2_STATUS, 16'h0000);
    rd(LIM_IDX_EVT_STATUS, 16'h0000);
    rd(30'h0000_0001, 16'h0000);
    chk("lines", lns, 4'h0);
  endtask : t_reset
  task automatic t_regs;
    logic [31:0] r;
    wr(LIM_IDX_G1_ENABLE, 16'hFFFF);
    rd(LIM_IDX_G1_ENABLE, 16'h2BEF);
    wb(1'b1, LIM_IDX_G1_ENABLE, 16'h0000, 4'h1, r);
    rd(LIM_IDX_G1_ENABLE, 16'h2B00);
    wr(LIM_IDX_ROUTE, 16'hFFFF);
    rd(LIM_IDX_ROUTE, 16'h0001);
    wr(LIM_IDX_ROUTE, 16'h0000);
    wr(LIM_IDX_G2_STATUS, 16'hFFFF);
    rd(LIM_IDX_G2_STATUS, 16'h0000);
  endtask : t_regs
  task automatic t_gate;
    for (int i = 0; i < 14; i++) begin
      if (!(16'h23EF >> i & 16'h0001)) continue;
      g1 <= 16'h0001 << i;
      wr(LIM_IDX_G1_ENABLE, ~(16'h0001 << i));
      repeat (2) @(posedge clk_sys);
      chk("blocked", lns, 4'h0);
      wr(LIM_IDX_G1_ENABLE, 16'h0001 << i);
      repeat (2) @(posedge clk_sys);
      chk("gated", lns, i == 0 ? 4'h8 : i == 2 ? 4'h2 : 4'h4);
    end
    g1 <= 16'h0001;
    wr(LIM_IDX_G1_ENABLE, 16'h0001);
    wr(LIM_IDX_ROUTE, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk("routed", lns, 4'h4);
    g1 <= 16'h0000;
  endtask : t_gate
  task automatic t_soft;
    wr(LIM_IDX_G1_ENABLE, 16'h0800);
    wr(LIM_IDX_SW_TRIGGER, 16'h0001);
    rd(LIM_IDX_G1_STATUS, 16'h0800);
    rd(LIM_IDX_SW_TRIGGER, 16'h0000);
    chk("soft line", lns, 4'h4);
    wr(LIM_IDX_SW_TRIGGER, 16'h0000);
    rd(LIM_IDX_G1_STATUS, 16'h0000);
    chk("soft off", lns, 4'h0);
  endtask : t_soft
  task automatic t_g2;
    g2 <= 16'hFFFF;
    g2en <= 16'h0001;
    rd(LIM_IDX_G2_STATUS, 16'h006F);
    chk("line two", lns, 4'h1);
    g2en <= 16'h0040;
    repeat (2) @(posedge clk_sys);
    chk("display", lns, 4'h4);
    chk("cpu seen", seen, 4'hF);
  endtask : t_g2
  task automatic t_irq;
    chk("irq masked", irq, 1'b0);
    wr(LIM_IDX_EVT_MASK, 16'h0002);
    repeat (2) @(posedge clk_sys);
    chk("irq up", irq, 1'b1);
    wr(LIM_IDX_EVT_STATUS, 16'h0002);
    rd(LIM_IDX_EVT_STATUS, 16'h000D);
    chk("irq cleared", irq, 1'b0);
    g2en <= 16'h0000;
    repeat (2) @(posedge clk_sys);
    g2en <= 16'h0040;
    repeat (3) @(posedge clk_sys);
    chk("irq again", irq, 1'b1);
  endtask : t_irq
  task automatic t_midreset;
    g2 <= 16'h0000;
    g2en <= 16'h0000;
    wr(LIM_IDX_G1_ENABLE, 16'hFFFF);
    wr(LIM_IDX_SW_TRIGGER, 16'h0001);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
  endtask : t_midreset

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_regs;
    t_gate;
    t_soft;
    t_g2;
    t_irq;
    t_midreset;
    tally_and_finish;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #200us;
    bad_count++;
    tally_and_finish;
  end
endmodule : lim_irq_tb_top

bind lim_irq_top lim_irq_checker u_chk (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .group1_request(group1_request), .group2_request(group2_request),
  .group2_enable(group2_enable), .cpu_nmi(cpu_nmi), .cpu_line_one(cpu_line_one),
  .cpu_general_line_zero(cpu_general_line_zero), .cpu_line_two(cpu_line_two), .irq(irq));

`default_nettype wire
